// ==== core/swp_pkg.sv ====
// Notes on behaviour
// - Four byte registers per port, 0x10 apart
// - Ingress filter drops frames outside VID membership
// - Drop frames whose VID differs from default
// - Forced flow control overrides autonegotiation result
// - Ports 1,2 force bit reset from strap
// - Port 3 force bit inert, global bit rules
// - Back pressure enable, resets to zero
// - Transmit enable gates transmission, resets one
// - Receive enable gates reception, resets one
// - Learning disable stops source learning, resets zero
// - Tag high byte: priority, CFI, VID high
// - Tag low byte VID low, resets 0x01
// - Default tag for untagged ingress, egress tagging
// - Untagged or null VID looks up default
// - Limit mode selects counted frame classes
// - Count IFG adds twelve bytes per frame
// - Count preamble adds eight bytes per frame
package swp_pkg;
  // Port count and bus geometry
  localparam int          SWP_NUM_PORTS  = 3;
  localparam int          SWP_ADDR_W     = 8;
  localparam int          SWP_LEN_W      = 16;
  // Register indices; byte address is four times the index
  localparam logic [5:0]  SWP_IDX_P1_CTRL2 = 6'h12;
  localparam logic [5:0]  SWP_IDX_P1_TAGHI = 6'h13;
  localparam logic [5:0]  SWP_IDX_P1_TAGLO = 6'h14;
  localparam logic [5:0]  SWP_IDX_P1_CTRL5 = 6'h15;
  localparam logic [5:0]  SWP_IDX_P2_CTRL2 = 6'h22;
  localparam logic [5:0]  SWP_IDX_P2_TAGHI = 6'h23;
  localparam logic [5:0]  SWP_IDX_P2_TAGLO = 6'h24;
  localparam logic [5:0]  SWP_IDX_P2_CTRL5 = 6'h25;
  localparam logic [5:0]  SWP_IDX_P3_CTRL2 = 6'h32;
  localparam logic [5:0]  SWP_IDX_P3_TAGHI = 6'h33;
  localparam logic [5:0]  SWP_IDX_P3_TAGLO = 6'h34;
  localparam logic [5:0]  SWP_IDX_P3_CTRL5 = 6'h35;
  // Register slot within a port (low nibble of the index)
  localparam logic [3:0]  SWP_SLOT_CTRL2 = 4'h2;
  localparam logic [3:0]  SWP_SLOT_TAGHI = 4'h3;
  localparam logic [3:0]  SWP_SLOT_TAGLO = 4'h4;
  localparam logic [3:0]  SWP_SLOT_CTRL5 = 4'h5;
  // Filter and flow control byte fields
  localparam int          SWP_BIT_VLAN_FILT = 6;
  localparam int          SWP_BIT_NON_DEFVID = 5;
  localparam int          SWP_BIT_FORCE_FC  = 4;
  localparam int          SWP_BIT_BACKPRESS = 3;
  localparam int          SWP_BIT_TX_EN     = 2;
  localparam int          SWP_BIT_RX_EN     = 1;
  localparam int          SWP_BIT_LEARN_DIS = 0;
  // Rate count mode byte fields
  localparam int          SWP_BIT_LIMIT_HI  = 3;
  localparam int          SWP_BIT_LIMIT_LO  = 2;
  localparam int          SWP_BIT_CNT_IFG   = 1;
  localparam int          SWP_BIT_CNT_PRE   = 0;
  // Reset values; force bit is overlaid from the strap
  localparam logic [7:0]  SWP_CTRL2_RST = 8'h06;
  localparam logic [7:0]  SWP_TAGHI_RST = 8'h00;
  localparam logic [7:0]  SWP_TAGLO_RST = 8'h01;
  localparam logic [7:0]  SWP_CTRL5_RST = 8'h00;
  // Extra bytes added to rate accounting
  localparam logic [15:0] SWP_IFG_BYTES = 16'h000c;
  localparam logic [15:0] SWP_PRE_BYTES = 16'h0008;
  // Null VID value
  localparam logic [11:0] SWP_NULL_VID  = 12'h000;

  // Ingress limit frame classes
  typedef enum logic [1:0] {
    SWP_LIM_ALL   = 2'b00,
    SWP_LIM_FLOOD = 2'b01,
    SWP_LIM_MCAST = 2'b10,
    SWP_LIM_BCAST = 2'b11
  } swp_limit_t;

  // Bus slave states
  typedef enum logic [1:0] {
    SWP_ST_IDLE   = 2'b01,
    SWP_ST_ACCESS = 2'b10
  } swp_state_t;
endpackage : swp_pkg

// ==== core/swp_port_regs.sv ====
`timescale 1ns/10ps
// One port's four control bytes
module swp_port_regs
  import swp_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       forceStrap,
  input  wire logic       wrEn,
  input  wire logic [3:0] wrSlot,
  input  wire logic [7:0] wrData,
  output logic      [7:0] ctrl2,
  output logic      [7:0] tagHigh,
  output logic      [7:0] tagLow,
  output logic      [7:0] ctrl5
);
  // Filter and flow byte; force bit follows the strap while reset is held
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      ctrl2 <= SWP_CTRL2_RST | {3'h0, forceStrap, 4'h0};
    else if (wrEn && wrSlot == SWP_SLOT_CTRL2)
      ctrl2 <= wrData;
  end

  // Default tag bytes
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tagHigh <= SWP_TAGHI_RST;
      tagLow  <= SWP_TAGLO_RST;
    end
    else if (wrEn && wrSlot == SWP_SLOT_TAGHI)
      tagHigh <= wrData;
    else if (wrEn && wrSlot == SWP_SLOT_TAGLO)
      tagLow <= wrData;
  end

  // Rate count mode byte
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      ctrl5 <= SWP_CTRL5_RST;
    else if (wrEn && wrSlot == SWP_SLOT_CTRL5)
      ctrl5 <= wrData;
  end
endmodule : swp_port_regs

// ==== core/swp_frame_check.sv ====
`timescale 1ns/10ps
// Per-port ingress decision and byte accounting, combinational
module swp_frame_check
  import swp_pkg::*;
#(
  parameter int PORT_ID = 0
)
(
  input  wire logic [7:0]  ctrl2,
  input  wire logic [7:0]  tagHigh,
  input  wire logic [7:0]  tagLow,
  input  wire logic [7:0]  ctrl5,
  input  wire logic        rxTagged,
  input  wire logic [11:0] rxVid,
  input  wire logic [2:0]  vlanMember,
  input  wire logic        isBcast,
  input  wire logic        isMcast,
  input  wire logic        isFlood,
  input  wire logic [15:0] rxLen,
  input  wire logic [15:0] txLen,
  output logic             drop,
  output logic      [11:0] effVid,
  output logic             counted,
  output logic      [15:0] rxAcct,
  output logic      [15:0] txAcct
);
  logic [11:0] defaultVid; // VID part of the default tag
  logic [15:0] extra;      // Gap and preamble bytes per frame
  swp_limit_t  mode;       // Selected limit class

  assign defaultVid = {tagHigh[3:0], tagLow};
  assign mode       = swp_limit_t'(ctrl5[SWP_BIT_LIMIT_HI:SWP_BIT_LIMIT_LO]);

  // Lookup VID: default for untagged or null-tagged frames
  always_comb
  begin
    if (!rxTagged || rxVid == SWP_NULL_VID)
      effVid = defaultVid;
    else
      effVid = rxVid;
  end

  // Drop decision
  always_comb
  begin
    drop = 1'b0;
    if (!ctrl2[SWP_BIT_RX_EN])
      drop = 1'b1;
    if (ctrl2[SWP_BIT_VLAN_FILT] && !vlanMember[PORT_ID])
      drop = 1'b1;
    if (ctrl2[SWP_BIT_NON_DEFVID] && effVid != defaultVid)
      drop = 1'b1;
  end

  // Frame class selection for ingress limiting
  always_comb
  begin
    case (mode)
      SWP_LIM_ALL:   counted = 1'b1;
      SWP_LIM_FLOOD: counted = isBcast | isMcast | isFlood;
      SWP_LIM_MCAST: counted = isBcast | isMcast;
      SWP_LIM_BCAST: counted = isBcast;
      default:       counted = 1'b1;
    endcase
  end

  // Extra accounting bytes
  always_comb
  begin
    extra = 16'h0000;
    if (ctrl5[SWP_BIT_CNT_IFG])
      extra = extra + SWP_IFG_BYTES;
    if (ctrl5[SWP_BIT_CNT_PRE])
      extra = extra + SWP_PRE_BYTES;
  end

  assign rxAcct = rxLen + extra;
  assign txAcct = txLen + extra;
endmodule : swp_frame_check

// ==== core/swp_port_ctrl.sv ====
`timescale 1ns/10ps
// Per-port control register bank for the three-port switch, APB slave
module swp_port_ctrl
  import swp_pkg::*;
(
  input  wire logic                                mclk,
  input  wire logic                                rst_n,
  // APB slave
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [SWP_ADDR_W-1:0]               paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // Straps and flow control sources
  input  wire logic                                firstPortFlowForceStrap,
  input  wire logic                                secondPortFlowForceStrap,
  input  wire logic                                port3GlobalFlowCtrl,
  input  wire logic [SWP_NUM_PORTS-1:0]            anFlowCtrl,
  // Ingress frame descriptors
  input  wire logic [SWP_NUM_PORTS-1:0]            rxFrameValid,
  input  wire logic [SWP_NUM_PORTS-1:0]            rxTagged,
  input  wire logic [SWP_NUM_PORTS-1:0][11:0]      rxVid,
  input  wire logic [SWP_NUM_PORTS-1:0][2:0]       rxVlanMember,
  input  wire logic [SWP_NUM_PORTS-1:0]            rxBcast,
  input  wire logic [SWP_NUM_PORTS-1:0]            rxMcast,
  input  wire logic [SWP_NUM_PORTS-1:0]            rxFlood,
  input  wire logic [SWP_NUM_PORTS-1:0][15:0]      rxFrameLen,
  // Egress frame requests
  input  wire logic [SWP_NUM_PORTS-1:0]            txFrameReq,
  input  wire logic [SWP_NUM_PORTS-1:0][15:0]      txFrameLen,
  // Ingress decisions
  output logic      [SWP_NUM_PORTS-1:0]            rxDrop,
  output logic      [SWP_NUM_PORTS-1:0]            rxAccept,
  output logic      [SWP_NUM_PORTS-1:0][11:0]      lookupVid,
  output logic      [SWP_NUM_PORTS-1:0]            learnEnable,
  output logic      [SWP_NUM_PORTS-1:0]            rateCounted,
  output logic      [SWP_NUM_PORTS-1:0][15:0]      rxAccountLen,
  // Egress decisions
  output logic      [SWP_NUM_PORTS-1:0]            txGrant,
  output logic      [SWP_NUM_PORTS-1:0][15:0]      txAccountLen,
  output logic      [SWP_NUM_PORTS-1:0][15:0]      egressTag,
  // Port level settings
  output logic      [SWP_NUM_PORTS-1:0]            fdxFlowCtrlEn,
  output logic      [SWP_NUM_PORTS-1:0]            backPressureEn,
  output logic      [SWP_NUM_PORTS-1:0]            txEnable,
  output logic      [SWP_NUM_PORTS-1:0]            rxEnable,
  output logic      [SWP_NUM_PORTS-1:0]            learnDisable
);
  // Bus slave state
  swp_state_t state;

  // Address decode
  logic [5:0]  regIndex;   // Word index taken from the byte address
  logic [3:0]  regSlot;    // Register slot within a port
  logic [1:0]  portNum;    // One-based port number from the index
  logic [1:0]  portSel;    // Zero-based port
  logic        addrHit;    // Address maps onto a register
  logic        wrStrobe;   // Write takes effect this edge
  logic [7:0]  rdByte;     // Selected register byte

  // Register contents per port
  logic [SWP_NUM_PORTS-1:0][7:0]  ctrl2;
  logic [SWP_NUM_PORTS-1:0][7:0]  tagHigh;
  logic [SWP_NUM_PORTS-1:0][7:0]  tagLow;
  logic [SWP_NUM_PORTS-1:0][7:0]  ctrl5;

  // Combinational frame decisions per port
  logic [SWP_NUM_PORTS-1:0]       chkDrop;
  logic [SWP_NUM_PORTS-1:0][11:0] chkVid;
  logic [SWP_NUM_PORTS-1:0]       chkCounted;
  logic [SWP_NUM_PORTS-1:0][15:0] chkRxAcct;
  logic [SWP_NUM_PORTS-1:0][15:0] chkTxAcct;
  logic [SWP_NUM_PORTS-1:0]       strap;

  // Index is the byte address divided by four
  assign regIndex = paddr[SWP_ADDR_W-1:2];
  assign regSlot  = regIndex[3:0];
  assign portNum  = regIndex[5:4];
  assign portSel  = portNum - 2'd1;

  // Only aligned word addresses of the twelve registers hit
  always_comb
  begin
    addrHit = 1'b0;
    if (paddr[1:0] == 2'b00 && portNum != 2'd0 &&
        regSlot >= SWP_SLOT_CTRL2 && regSlot <= SWP_SLOT_CTRL5)
      addrHit = 1'b1;
  end

  // Read mux over the selected port's bytes
  always_comb
  begin
    rdByte = 8'h00;
    if (addrHit)
    begin
      case (regSlot)
        SWP_SLOT_CTRL2: rdByte = ctrl2[portSel];
        SWP_SLOT_TAGHI: rdByte = tagHigh[portSel];
        SWP_SLOT_TAGLO: rdByte = tagLow[portSel];
        SWP_SLOT_CTRL5: rdByte = ctrl5[portSel];
        default:        rdByte = 8'h00;
      endcase
    end
  end

  // Write lands at the access edge while pready is high
  assign wrStrobe = (state == SWP_ST_ACCESS) && psel && penable && pwrite && addrHit;

  // APB handshake: no wait states, answer registered at the setup edge
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state   <= SWP_ST_IDLE;
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      case (state)
        SWP_ST_IDLE:
        begin
          // Setup phase seen: prepare answer for the access phase
          if (psel && !penable)
          begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
            pslverr <= !addrHit;
            state   <= SWP_ST_ACCESS;
          end
          else
          begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
          end
        end
        SWP_ST_ACCESS:
        begin
          // Access completes this edge; release the answer
          pready  <= 1'b0;
          pslverr <= 1'b0;
          state   <= SWP_ST_IDLE;
        end
        default:
        begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          state   <= SWP_ST_IDLE;
        end
      endcase
    end
  end

  // Strap per port; the third port has none
  assign strap = {1'b0, secondPortFlowForceStrap, firstPortFlowForceStrap};

  // Per-port register set and frame check
  for (genvar p = 0; p < SWP_NUM_PORTS; p++)
  begin : gPort
    // Register bytes, written only when this port is addressed
    swp_port_regs uRegs (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .forceStrap (strap[p]),
      .wrEn       (wrStrobe && portSel == 2'(p)),
      .wrSlot     (regSlot),
      .wrData     (pwdata[7:0]),
      .ctrl2      (ctrl2[p]),
      .tagHigh    (tagHigh[p]),
      .tagLow     (tagLow[p]),
      .ctrl5      (ctrl5[p])
    );

    // Ingress decision and accounting
    swp_frame_check #(
      .PORT_ID (p)
    ) uCheck (
      .ctrl2      (ctrl2[p]),
      .tagHigh    (tagHigh[p]),
      .tagLow     (tagLow[p]),
      .ctrl5      (ctrl5[p]),
      .rxTagged   (rxTagged[p]),
      .rxVid      (rxVid[p]),
      .vlanMember (rxVlanMember[p]),
      .isBcast    (rxBcast[p]),
      .isMcast    (rxMcast[p]),
      .isFlood    (rxFlood[p]),
      .rxLen      (rxFrameLen[p]),
      .txLen      (txFrameLen[p]),
      .drop       (chkDrop[p]),
      .effVid     (chkVid[p]),
      .counted    (chkCounted[p]),
      .rxAcct     (chkRxAcct[p]),
      .txAcct     (chkTxAcct[p])
    );
  end

  // Port level settings registered out; new values act on the next edge
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      fdxFlowCtrlEn  <= '0;
      backPressureEn <= '0;
      txEnable       <= '0;
      rxEnable       <= '0;
      learnDisable   <= '0;
      egressTag      <= '0;
    end
    else
    begin
      for (int i = 0; i < SWP_NUM_PORTS; i++)
      begin
        // Third port ignores its force bit and follows the global setting
        if (i == SWP_NUM_PORTS - 1)
          fdxFlowCtrlEn[i] <= port3GlobalFlowCtrl;
        else
          fdxFlowCtrlEn[i] <= ctrl2[i][SWP_BIT_FORCE_FC] | anFlowCtrl[i];
        backPressureEn[i] <= ctrl2[i][SWP_BIT_BACKPRESS];
        txEnable[i]       <= ctrl2[i][SWP_BIT_TX_EN];
        rxEnable[i]       <= ctrl2[i][SWP_BIT_RX_EN];
        learnDisable[i]   <= ctrl2[i][SWP_BIT_LEARN_DIS];
        egressTag[i]      <= {tagHigh[i], tagLow[i]};
      end
    end
  end

  // Ingress results, one cycle after the descriptor
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rxDrop       <= '0;
      rxAccept     <= '0;
      lookupVid    <= '0;
      learnEnable  <= '0;
      rateCounted  <= '0;
      rxAccountLen <= '0;
    end
    else
    begin
      for (int i = 0; i < SWP_NUM_PORTS; i++)
      begin
        // Pulses only for a valid descriptor
        rxDrop[i]       <= rxFrameValid[i] & chkDrop[i];
        rxAccept[i]     <= rxFrameValid[i] & ~chkDrop[i];
        lookupVid[i]    <= chkVid[i];
        // Learning only on accepted frames with learning left on
        learnEnable[i]  <= rxFrameValid[i] & ~chkDrop[i] & ~ctrl2[i][SWP_BIT_LEARN_DIS];
        rateCounted[i]  <= rxFrameValid[i] & ~chkDrop[i] & chkCounted[i];
        rxAccountLen[i] <= chkRxAcct[i];
      end
    end
  end

  // Egress grants, gated by transmit enable
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      txGrant      <= '0;
      txAccountLen <= '0;
    end
    else
    begin
      for (int i = 0; i < SWP_NUM_PORTS; i++)
      begin
        txGrant[i]      <= txFrameReq[i] & ctrl2[i][SWP_BIT_TX_EN];
        txAccountLen[i] <= chkTxAcct[i];
      end
    end
  end
endmodule : swp_port_ctrl

// ==== testbench/swp_port_ctrl_monitor.sv ====
`timescale 1ns/10ps
// Watches bus answers, frame verdicts and settings at the bank's ports
module swp_port_ctrl_monitor
  import swp_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        port3GlobalFlowCtrl,
  input wire logic [2:0]  rxFrameValid,
  input wire logic [2:0]  txFrameReq,
  input wire logic [2:0]  rxDrop,
  input wire logic [2:0]  rxAccept,
  input wire logic [2:0]  txGrant,
  input wire logic [2:0]  fdxFlowCtrlEn,
  input wire logic [2:0]  txEnable,
  input wire logic [2:0]  rxEnable
);
  // Aligned word on one of the twelve control bytes
  logic mapped;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr[7:6] != 2'b00) && (paddr[5:2] >= 4'h2) && (paddr[5:2] <= 4'h5);

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_ANSWER_NEXT: assert property (psel && !penable |=> pready)
    else $error("no bus answer one cycle after setup");
  AST_ANSWER_PULSE: assert property (pready |=> !pready)
    else $error("bus answer longer than one cycle");
  AST_ERR_UNMAPPED: assert property (psel && !penable && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_OK_MAPPED: assert property (psel && !penable && mapped |=> !pslverr)
    else $error("mapped access refused");
  AST_ONE_VERDICT: assert property (rxFrameValid != 3'h0 |=>
    ((rxDrop ^ rxAccept) == $past(rxFrameValid)) && ((rxDrop & rxAccept) == 3'h0))
    else $error("frame verdict missing or doubled");
  AST_RX_OFF_DROP: assert property (rxFrameValid[1] && !rxEnable[1] ##1 !rxEnable[1] |-> rxDrop[1])
    else $error("frame accepted with reception off");
  AST_TX_GATE: assert property ($past(rst_n) |-> txGrant == ($past(txFrameReq) & txEnable))
    else $error("transmit grant not gated by enable");
  AST_P3_FLOW: assert property ($past(rst_n, 2) && $past(rst_n) && $stable(port3GlobalFlowCtrl)
    |-> fdxFlowCtrlEn[2] == port3GlobalFlowCtrl)
    else $error("third port flow control not from global bit");
endmodule : swp_port_ctrl_monitor

bind swp_port_ctrl swp_port_ctrl_monitor u_mon (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port3GlobalFlowCtrl(port3GlobalFlowCtrl),
  .rxFrameValid(rxFrameValid), .txFrameReq(txFrameReq), .rxDrop(rxDrop), .rxAccept(rxAccept),
  .txGrant(txGrant), .fdxFlowCtrlEn(fdxFlowCtrlEn), .txEnable(txEnable), .rxEnable(rxEnable));

// ==== testbench/swp_port_ctrl_tb_top.sv ====
`timescale 1ns/10ps
// Bus accesses, frame descriptors and settings checks for the control bank
module swp_port_ctrl_tb_top
  import swp_pkg::*;
;
  logic                mclk = 1'b0;
  logic                rst_n = 1'b0;
  logic                psel, penable, pwrite, pready, pslverr, strap1, strap2, glob;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata;
  logic [2:0]          an, txReq, rxV, rxT, rxB, rxM, rxF, rxDrop, rxAccept, learnEnable, rateCounted;
  logic [2:0]          txGrant, fdx, bp, txEn, rxEn, lrnDis;
  logic [2:0][11:0]    rxVid, lookupVid;
  logic [2:0][2:0]     mem;
  logic [2:0][15:0]    rxLen, txLen, rxAcctLen, txAcctLen, egressTag;
  logic [7:0]          mdl [3][6];    // Expected register bytes, indexed by slot
  int                  fails = 0;
  int                  n_tests = 0;

  // 125 MHz clock
  always #4 mclk = ~mclk;

  swp_port_ctrl dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .firstPortFlowForceStrap(strap1), .secondPortFlowForceStrap(strap2), .port3GlobalFlowCtrl(glob),
    .anFlowCtrl(an), .rxFrameValid(rxV), .rxTagged(rxT), .rxVid(rxVid), .rxVlanMember(mem), .rxBcast(rxB),
    .rxMcast(rxM), .rxFlood(rxF), .rxFrameLen(rxLen), .txFrameReq(txReq), .txFrameLen(txLen),
    .rxDrop(rxDrop), .rxAccept(rxAccept), .lookupVid(lookupVid), .learnEnable(learnEnable),
    .rateCounted(rateCounted), .rxAccountLen(rxAcctLen), .txGrant(txGrant), .txAccountLen(txAcctLen),
    .egressTag(egressTag), .fdxFlowCtrlEn(fdx), .backPressureEn(bp), .txEnable(txEn), .rxEnable(rxEn),
    .learnDisable(lrnDis));

  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x)
    begin
      fails++;
      $display("BAD t=%0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  // Verdict and end of run
  task automatic end_of_test();
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // Byte address of a port's slot
  function automatic logic [7:0] addrOf(input int p, input int s);
    return {p[1:0] + 2'd1, s[3:0], 2'b00};
  endfunction : addrOf

  // Gap and preamble bytes added to a frame's accounting
  function automatic logic [15:0] extra(input int p);
    return (mdl[p][5][1] ? 16'd12 : 16'd0) + (mdl[p][5][0] ? 16'd8 : 16'd0);
  endfunction : extra

  // Expected reset contents, force bit from the straps
  task automatic mdlReset();
    for (int p = 0; p < 3; p++)
    begin
      mdl[p][2] = 8'h06 | {3'h0, (p == 0) ? strap1 : ((p == 1) ? strap2 : 1'b0), 4'h0};
      mdl[p][3] = 8'h00;
      mdl[p][4] = 8'h01;
      mdl[p][5] = 8'h00;
    end
  endtask : mdlReset

  // One bus transfer; holds the request until pready is seen high
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] x, input logic e);
    int          n;
    logic [31:0] sr;
    logic        se;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    // Look at the registered answer while it settles ahead of the access edge
    @(negedge mclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 50)
      fails++;
    sr = prdata;
    se = pslverr;
    // Access edge: write lands here; read data was taken at the negedge before
    @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
    chk(sr, {24'h0, x});
    chk({31'h0, se}, {31'h0, e});
    @(posedge mclk);
  endtask : acc

  task automatic wr(input int p, input int s, input logic [7:0] d);
    mdl[p][s] = d;
    acc(1'b1, addrOf(p, s), d, 8'h00, 1'b0);
  endtask : wr

  task automatic rd(input int p, input int s);
    acc(1'b0, addrOf(p, s), 8'h00, mdl[p][s], 1'b0);
  endtask : rd

  // Reads back every control byte of every port
  task automatic rdAll();
    for (int p = 0; p < 3; p++)
      for (int s = 2; s < 6; s++)
        rd(p, s);
  endtask : rdAll

  // Port level settings against the expected bytes
  task automatic setChk();
    @(negedge mclk);
    for (int p = 0; p < 3; p++)
    begin
      chk(32'(fdx[p]), 32'((p < 2) ? (mdl[p][2][4] | an[p]) : glob));
      chk(32'(bp[p]), 32'(mdl[p][2][3]));
      chk(32'(txEn[p]), 32'(mdl[p][2][2]));
      chk(32'(rxEn[p]), 32'(mdl[p][2][1]));
      chk(32'(lrnDis[p]), 32'(mdl[p][2][0]));
      chk(32'(egressTag[p]), {16'h0, mdl[p][3], mdl[p][4]});
    end
    @(posedge mclk);
  endtask : setChk

  // One frame descriptor and its verdict a cycle later
  task automatic rx(input int p, input logic t, input logic [11:0] v, input logic [2:0] m, input logic [2:0] c);
    logic [11:0] pv, ev;
    logic [1:0]  md;
    logic        dr, cn;
    pv = {mdl[p][3][3:0], mdl[p][4]};
    ev = (!t || v == 12'h0) ? pv : v;
    md = mdl[p][5][3:2];
    dr = !mdl[p][2][1] || (mdl[p][2][6] && !m[p]) || (mdl[p][2][5] && ev != pv);
    cn = md == 2'd0 || (md == 2'd1 && c != 3'h0) || (md == 2'd2 && c[2:1] != 2'h0) || (md == 2'd3 && c[2]);
    rxV[p] <= 1'b1;
    rxT[p] <= t;
    rxVid[p] <= v;
    mem[p] <= m;
    {rxB[p], rxM[p], rxF[p]} <= c;
    rxLen[p] <= 16'd100 + 16'(p);
    @(posedge mclk);
    rxV[p] <= 1'b0;
    @(negedge mclk);
    chk(32'(rxDrop[p]), 32'(dr));
    chk(32'(lookupVid[p]), 32'(ev));
    chk(32'(learnEnable[p]), 32'(!dr && !mdl[p][2][0]));
    chk(32'(rxAcctLen[p]), 32'(16'd100 + 16'(p) + extra(p)));
    if (!dr)
      chk(32'(rateCounted[p]), 32'(cn));
    @(posedge mclk);
  endtask : rx

  // Egress requests on all ports
  task automatic txChk();
    txReq <= 3'b111;
    txLen <= {16'd300, 16'd200, 16'd64};
    @(posedge mclk);
    @(negedge mclk);
    for (int p = 0; p < 3; p++)
    begin
      chk(32'(txGrant[p]), 32'(mdl[p][2][2]));
      chk(32'(txAcctLen[p]), 32'(txLen[p] + extra(p)));
    end
    @(posedge mclk);
    txReq <= 3'b000;
  endtask : txChk

  // Watchdog
  initial
  begin
    repeat (8000) @(posedge mclk);
    fails++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, strap2, glob, an, txReq, rxV, rxT, rxB, rxM, rxF} <= '0;
    {rxVid, mem, rxLen, txLen} <= '0;
    strap1 <= 1'b1;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    mdlReset();
    rdAll();
    setChk();
    acc(1'b0, 8'h40, 8'h00, 8'h00, 1'b1);
    acc(1'b0, 8'h49, 8'h00, 8'h00, 1'b1);
    acc(1'b1, 8'hd8, 8'hff, 8'h00, 1'b1);
    for (int p = 0; p < 3; p++)
    begin
      rx(p, 1'b0, 12'h123, 3'h7, 3'h0);
      rx(p, 1'b1, 12'h005, 3'h7, 3'h0);
    end
    // Every limit mode, each paired with one of the four gap and preamble settings
    for (int md = 0; md < 4; md++)
    begin
      wr(1, 5, 8'(md * 5));
      rd(1, 5);
      for (int c = 0; c < 8; c++)
        rx(1, 1'b0, 12'h0, 3'h7, 3'(c));
    end
    // Membership filter and default VID discard on the first port
    wr(0, 2, 8'h66);
    rx(0, 1'b1, 12'h001, 3'h6, 3'h0);
    rx(0, 1'b1, 12'h001, 3'h1, 3'h0);
    rx(0, 1'b1, 12'h002, 3'h1, 3'h0);
    rx(0, 1'b1, 12'h000, 3'h1, 3'h0);
    wr(0, 3, 8'ha3);
    wr(0, 4, 8'h45);
    rx(0, 1'b1, 12'h345, 3'h1, 3'h0);
    rx(0, 1'b0, 12'h001, 3'h1, 3'h4);
    // Second port closed, third port force bit inert
    wr(1, 2, 8'h19);
    wr(2, 2, 8'h16);
    glob <= 1'b1;
    @(posedge mclk);
    setChk();
    rx(1, 1'b0, 12'h0, 3'h7, 3'h0);
    txChk();
    an <= 3'b001;
    glob <= 1'b0;
    @(posedge mclk);
    setChk();
    rdAll();
    // Second reset with the straps swapped
    rst_n <= 1'b0;
    strap1 <= 1'b0;
    strap2 <= 1'b1;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    mdlReset();
    rdAll();
    setChk();
    end_of_test();
  end
endmodule : swp_port_ctrl_tb_top
